// file: psi_pkg.sv
// Notes on behaviour
// - read-only status word at address 0x01, reset 0x7849
// - bits 14..11 report the four line modes
// - remote fault latches until status read
// - jabber latches at bit 1 until read
// - link bit reads one only with link
// - bit 3 reports auto-negotiation ability
// - bit 0 reports extended registers present
// - negotiation done only when results valid
// - bit 6 reports preamble-less frames accepted
// - reserved bits 15 and 10:7 read zero
// - identifier words at addresses 0x02 and 0x03
// - second word: vendor low, model, revision
// - vendor id split across both words
package psi_pkg;

   // register addresses on the management port
   localparam logic [4:0]  ADDR_STATUS    = 5'h01;
   localparam logic [4:0]  ADDR_ID_UPPER  = 5'h02;
   localparam logic [4:0]  ADDR_ID_LOWER  = 5'h03;
   localparam logic [4:0]  ADDR_IRQ_STAT  = 5'h10;
   localparam logic [4:0]  ADDR_IRQ_MASK  = 5'h11;

   // status word field positions
   localparam int          BIT_CAP_FF     = 14;
   localparam int          BIT_CAP_FH     = 13;
   localparam int          BIT_CAP_SF     = 12;
   localparam int          BIT_CAP_SH     = 11;
   localparam int          BIT_PREAMBLE   = 6;
   localparam int          BIT_AN_DONE    = 5;
   localparam int          BIT_REMOTE_FAULT_FLAG     = 4;
   localparam int          BIT_AN_CAP     = 3;
   localparam int          BIT_LINK       = 2;
   localparam int          BIT_JABBER     = 1;
   localparam int          BIT_EXTENDED_REGS_PRESENT       = 0;

   // fixed capability bits
   localparam logic        CAP_FAST_FULL  = 1'b1;
   localparam logic        CAP_FAST_HALF  = 1'b1;
   localparam logic        CAP_SLOW_FULL  = 1'b1;
   localparam logic        CAP_SLOW_HALF  = 1'b1;
   localparam logic        CAP_PREAMBLE   = 1'b1;
   localparam logic        CAP_AUTONEG    = 1'b1;
   localparam logic        CAP_EXTENDED   = 1'b1;
   localparam logic [15:0] STATUS_RESET   = 16'h7849;

   // identifier layout
   localparam int          OUI_W          = 22;
   localparam int          OUI_LO_W       = 6;
   localparam int          MODEL_W        = 6;
   localparam int          REV_W          = 4;

   // interrupt status bit positions
   localparam int          IRQ_N          = 4;
   localparam int          IRQ_REMOTE_FAULT_FLAG     = 0;
   localparam int          IRQ_JABBER     = 1;
   localparam int          IRQ_LINK_CHG   = 2;
   localparam int          IRQ_AN_DONE    = 3;
   localparam logic [3:0]  IRQ_RESET      = 4'h0;

   localparam logic [15:0] ZERO16         = 16'h0000;

   // conditions reported by the line side of the phy
   typedef struct packed {
      logic link_up;
      logic an_finished;
      logic an_results_valid;
      logic remote_fault;
      logic jabber;
   } psi_line_s;

endpackage

// file: psi_status_ident_regs.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module psi_status_ident_regs #(
   parameter logic [21:0] OUI_VALUE   = 22'h2A5A5, // arbitrary value
   parameter logic [5:0]  MODEL_VALUE = 6'h15,     // arbitrary value
   parameter logic [3:0]  REV_VALUE   = 4'h2       // arbitrary value
) (
   input  wire  logic               mclk,
   input  wire  logic               sys_rst,
   input  wire  logic               clk_en,
   input  wire  psi_pkg::psi_line_s line_in,
   input  wire  logic [4:0]         reg_addr,
   input  wire  logic [15:0]        reg_wdata,
   input  wire  logic               reg_wr,
   input  wire  logic               reg_rd,
   output logic [15:0]              reg_rdata,
   output logic                     irq
);

   logic                       link_reg;
   logic                       an_done_reg;
   logic                       remote_fault_flag_reg;
   logic                       jabber_reg;
   logic [psi_pkg::IRQ_N-1:0]  irq_stat_reg;
   logic [psi_pkg::IRQ_N-1:0]  irq_mask_reg;
   logic [psi_pkg::IRQ_N-1:0]  irq_event;
   logic [15:0]                status_word;
   logic [15:0]                id_upper;
   logic [15:0]                id_lower;
   logic [15:0]                rdata_next;
   logic                       status_rd;
   logic                       an_done_next;

   assign status_rd    = reg_rd && (reg_addr == psi_pkg::ADDR_STATUS);
   // done only when negotiation ended and result registers are valid
   assign an_done_next = line_in.an_finished && line_in.an_results_valid;

   // live link and negotiation state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         link_reg    <= 1'b0;
         an_done_reg <= 1'b0;
      end else if (clk_en) begin
         link_reg    <= line_in.link_up;
         an_done_reg <= an_done_next;
      end
   end

   // sticky remote fault: a present condition wins over the read clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         remote_fault_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (line_in.remote_fault) begin
            remote_fault_flag_reg <= 1'b1;
         end else if (status_rd) begin
            remote_fault_flag_reg <= 1'b0;
         end
      end
   end

   // sticky jabber flag, same scheme
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         jabber_reg <= 1'b0;
      end else if (clk_en) begin
         if (line_in.jabber) begin
            jabber_reg <= 1'b1;
         end else if (status_rd) begin
            jabber_reg <= 1'b0;
         end
      end
   end

   // assemble the status word; unlisted bits stay zero
   always_comb begin
      status_word                         = psi_pkg::ZERO16;
      status_word[psi_pkg::BIT_CAP_FF]    = psi_pkg::CAP_FAST_FULL;
      status_word[psi_pkg::BIT_CAP_FH]    = psi_pkg::CAP_FAST_HALF;
      status_word[psi_pkg::BIT_CAP_SF]    = psi_pkg::CAP_SLOW_FULL;
      status_word[psi_pkg::BIT_CAP_SH]    = psi_pkg::CAP_SLOW_HALF;
      status_word[psi_pkg::BIT_PREAMBLE]  = psi_pkg::CAP_PREAMBLE;
      status_word[psi_pkg::BIT_AN_DONE]   = an_done_reg;
      status_word[psi_pkg::BIT_REMOTE_FAULT_FLAG]    = remote_fault_flag_reg;
      status_word[psi_pkg::BIT_AN_CAP]    = psi_pkg::CAP_AUTONEG;
      status_word[psi_pkg::BIT_LINK]      = link_reg;
      status_word[psi_pkg::BIT_JABBER]    = jabber_reg;
      status_word[psi_pkg::BIT_EXTENDED_REGS_PRESENT]      = psi_pkg::CAP_EXTENDED;
   end

   // identifier words: vendor high bits, then vendor low, model, revision
   assign id_upper = OUI_VALUE[psi_pkg::OUI_W-1:psi_pkg::OUI_LO_W];
   assign id_lower = {OUI_VALUE[psi_pkg::OUI_LO_W-1:0], MODEL_VALUE, REV_VALUE};

   // interrupt events: flag rises, link changes, negotiation completes
   assign irq_event[psi_pkg::IRQ_REMOTE_FAULT_FLAG]   = line_in.remote_fault && !remote_fault_flag_reg;
   assign irq_event[psi_pkg::IRQ_JABBER]   = line_in.jabber && !jabber_reg;
   assign irq_event[psi_pkg::IRQ_LINK_CHG] = line_in.link_up != link_reg;
   assign irq_event[psi_pkg::IRQ_AN_DONE]  = an_done_next && !an_done_reg;

   // sticky interrupt status, write one to clear, event wins
   genvar gi;
   generate
      for (gi = 0; gi < psi_pkg::IRQ_N; gi++) begin : g_irq
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               irq_stat_reg[gi] <= psi_pkg::IRQ_RESET[gi];
            end else if (clk_en) begin
               if (irq_event[gi]) begin
                  irq_stat_reg[gi] <= 1'b1;
               end else if (reg_wr && (reg_addr == psi_pkg::ADDR_IRQ_STAT) && reg_wdata[gi]) begin
                  irq_stat_reg[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // interrupt mask, one enables the matching status bit
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_mask_reg <= psi_pkg::IRQ_RESET;
      end else if (clk_en && reg_wr && (reg_addr == psi_pkg::ADDR_IRQ_MASK)) begin
         irq_mask_reg <= reg_wdata[psi_pkg::IRQ_N-1:0];
      end
   end

   // level interrupt output
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // read decode; writes to the read-only words are ignored
   always_comb begin
      case (reg_addr)
         psi_pkg::ADDR_STATUS:   rdata_next = status_word;
         psi_pkg::ADDR_ID_UPPER: rdata_next = id_upper;
         psi_pkg::ADDR_ID_LOWER: rdata_next = id_lower;
         psi_pkg::ADDR_IRQ_STAT: rdata_next = {{(16-psi_pkg::IRQ_N){1'b0}}, irq_stat_reg};
         psi_pkg::ADDR_IRQ_MASK: rdata_next = {{(16-psi_pkg::IRQ_N){1'b0}}, irq_mask_reg};
         default:                rdata_next = psi_pkg::ZERO16;
      endcase
   end

   // read data stands in the cycle after the read strobe only
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= psi_pkg::ZERO16;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? rdata_next : psi_pkg::ZERO16;
      end
   end

endmodule
`default_nettype wire

// file: psi_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module psi_regs_props #(
   parameter logic [21:0] OUI_VALUE   = 22'h2A5A5,
   parameter logic [5:0]  MODEL_VALUE = 6'h15,
   parameter logic [3:0]  REV_VALUE   = 4'h2
) (
   input wire logic               mclk,
   input wire logic               sys_rst,
   input wire logic               clk_en,
   input wire psi_pkg::psi_line_s line_in,
   input wire logic [4:0]         reg_addr,
   input wire logic               reg_rd,
   input wire logic [15:0]        reg_rdata
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst || !clk_en);
   // read strobe at one address, and a cycle with no fault present
   sequence rd_at(logic [4:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence quiet;
      !line_in.remote_fault && !line_in.jabber;
   endsequence
   a_fixed_bits: assert property (rd_at(5'h01) |=> reg_rdata[15:6] == 10'h1E1 && reg_rdata[3] && reg_rdata[0])
      else $error("fixed status bits wrong");
   a_link_lag: assert property (rd_at(5'h01) |=> reg_rdata[2] == $past(line_in.link_up, 2))
      else $error("link bit wrong");
   a_an_done: assert property (rd_at(5'h01) |=>
      reg_rdata[5] == ($past(line_in.an_finished, 2) && $past(line_in.an_results_valid, 2)))
      else $error("negotiation done bit wrong");
   a_rf_sticky: assert property (line_in.remote_fault ##1 rd_at(5'h01) |=> reg_rdata[4])
      else $error("remote fault not latched");
   a_jab_sticky: assert property (line_in.jabber ##1 rd_at(5'h01) |=> reg_rdata[1])
      else $error("jabber not latched");
   a_flag_clear: assert property (rd_at(5'h01) ##0 quiet ##1 rd_at(5'h01) ##0 quiet |=> !reg_rdata[4] && !reg_rdata[1])
      else $error("fault flags not cleared by read");
   a_ident_hi: assert property (rd_at(5'h02) |=> reg_rdata == OUI_VALUE[21:6])
      else $error("upper identifier wrong");
   a_ident_lo: assert property (rd_at(5'h03) |=> reg_rdata == {OUI_VALUE[5:0], MODEL_VALUE, REV_VALUE})
      else $error("lower identifier wrong");
endmodule
`default_nettype wire

// file: psi_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module psi_line_model (
   input  wire logic               mclk,
   input  wire psi_pkg::psi_line_s cmd,
   output var  psi_pkg::psi_line_s line_out
);
   // line conditions change only at the clock edge
   always_ff @(posedge mclk) begin
      line_out <= cmd;
   end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [21:0] OUI = 22'h2A5A5; // arbitrary value
   localparam logic [15:0] ST  = 16'h7849;
   logic               mclk = 1'b0;
   logic               sys_rst = 1'b1;
   logic               clk_en = 1'b1;
   logic [4:0]         reg_addr = 5'h00;
   logic [15:0]        reg_wdata = 16'h0000;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [15:0]        reg_rdata;
   logic               irq;
   psi_pkg::psi_line_s cond = '0;
   psi_pkg::psi_line_s line_in;
   int                 fails = 0;
   int                 n_compared = 0;
   always #2 mclk = ~mclk;
   psi_line_model psi_line_model_inst (.mclk(mclk), .cmd(cond), .line_out(line_in));
   psi_status_ident_regs #(.OUI_VALUE(OUI)) psi_status_ident_regs_inst (.mclk(mclk), .sys_rst(sys_rst),
      .clk_en(clk_en), .line_in(line_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // two reads back to back, each answer checked in its own cycle
   task automatic rd2(input logic [4:0] a, input logic [15:0] e1, input logic [15:0] e2);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      #1 chk(reg_rdata, e1);
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e2);
   endtask
   // set line conditions and let them settle into the status word
   task automatic line(input psi_pkg::psi_line_s c);
      @(posedge mclk);
      cond <= c;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic test_done();
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(5'h01, ST);
      wr(5'h01, 16'hFFFF);
      rd(5'h01, ST);
      rd(5'h02, OUI[21:6]);
      rd(5'h03, {OUI[5:0], 6'h15, 4'h2});
      rd(5'h1F, 16'h0000);
      line(5'h10);
      rd(5'h01, ST | 16'h0004);
      line(5'h08);
      rd(5'h01, ST);
      line(5'h0C);
      rd(5'h01, ST | 16'h0020);
      line(5'h03);
      line(5'h00);
      rd2(5'h01, ST | 16'h0012, ST);
      line(5'h01);
      rd(5'h01, ST | 16'h0002);
      line(5'h00);
      rd(5'h01, ST | 16'h0002);
      rd(5'h01, ST);
      wr(5'h10, 16'h000F);
      rd(5'h10, 16'h0000);
      wr(5'h11, 16'h0001);
      line(5'h01);
      line(5'h00);
      chk({15'h0000, irq}, 16'h0000);
      rd(5'h10, 16'h0002);
      line(5'h02);
      line(5'h00);
      chk({15'h0000, irq}, 16'h0001);
      wr(5'h10, 16'h0001);
      line(5'h00);
      chk({15'h0000, irq}, 16'h0000);
      rd(5'h11, 16'h0001);
      test_done();
   end
   // cut a hang short
   initial begin
      repeat (3000) @(posedge mclk);
      fails++;
      test_done();
   end
endmodule
bind psi_status_ident_regs psi_regs_props #(.OUI_VALUE(OUI_VALUE), .MODEL_VALUE(MODEL_VALUE), .REV_VALUE(REV_VALUE))
   psi_regs_props_inst (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .line_in(line_in),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
